// *** sim/sfif_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module sfif_host_model (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      serial_data_line,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  initial
  begin
    spi_clk          = 1'h0;
    cs_n             = 1'h1;
    serial_data_line = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame: nbits from tx, MSB first; link clock still outside frames
  task automatic xfer(
    input  logic [63:0] tx,
    input  int          nbits,
    output logic [63:0] rx
  );
    rx = '0;
    // Odd offset keeps the link edges away from the core clock edges
    #1.7;
    cs_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      serial_data_line = tx[i];
      #32;
      spi_clk = 1'h1;
      // An undriven return line shows the inverse, never a lucky match
      rx = {rx[62:0], serial_out_oe_n ? ~serial_out : serial_out};
      #32;
      spi_clk = 1'h0;
    end
    #32;
    cs_n = 1'h1;
    serial_data_line = ~serial_data_line;
    // Deselect gap well above the 20 ns minimum
    #100;
  endtask
endmodule

`default_nettype wire

// *** sim/test_serial_flash_instruction_framer.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_serial_flash_instruction_framer;
  import sfif_pkg::*;

  logic        clock;
  logic        arst_n;
  wire         spi_clk;
  wire         cs_n;
  wire         serial_data_line;
  logic        serial_out;
  logic        serial_out_oe_n;
  logic        busy;
  logic        prot_en;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;
  logic [7:0]  rd_data;
  logic        cmd_go;
  logic [7:0]  cmd_op;
  logic [23:0] cmd_addr;
  logic        rd_start;
  logic        rd_next;
  logic        wr_valid;
  logic [7:0]  wr_byte;
  int          err_total;
  int          checks;
  int          go_n;
  int          rd_n;
  int          wv_n;
  int          rn_n;
  logic [7:0]  go_op;
  logic [23:0] go_addr;
  logic [7:0]  wr_last;
  logic [63:0] rx_bits;
  logic [7:0]  ops [5];

  sfif_top sfif_top_inst (
    .clock            (clock),
    .arst_n           (arst_n),
    .spi_clk          (spi_clk),
    .cs_n             (cs_n),
    .serial_data_line (serial_data_line),
    .serial_out       (serial_out),
    .serial_out_oe_n  (serial_out_oe_n),
    .busy             (busy),
    .prot_en          (prot_en),
    .prot_lo          (prot_lo),
    .prot_hi          (prot_hi),
    .rd_data          (rd_data),
    .cmd_go           (cmd_go),
    .cmd_op           (cmd_op),
    .cmd_addr         (cmd_addr),
    .rd_start         (rd_start),
    .rd_next          (rd_next),
    .wr_valid         (wr_valid),
    .wr_byte          (wr_byte)
  );

  sfif_host_model sfif_host_model_inst (
    .spi_clk          (spi_clk),
    .cs_n             (cs_n),
    .serial_data_line (serial_data_line),
    .serial_out       (serial_out),
    .serial_out_oe_n  (serial_out_oe_n)
  );

  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse monitor on the core side
  always @(posedge clock)
  begin
    if (cmd_go === 1'h1)
    begin
      go_n++;
      go_op = cmd_op;
      go_addr = cmd_addr;
    end
    if (rd_start === 1'h1)
      rd_n++;
    if (rd_next === 1'h1)
      rn_n++;
    if (wr_valid === 1'h1)
    begin
      wv_n++;
      wr_last = wr_byte;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (exp !== got)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Pulses land 3-4 cycles after deselect; ten cycles cover that
  task automatic frame(input logic [63:0] tx, input int nb);
    #1;
    go_n = 0;
    rd_n = 0;
    wv_n = 0;
    rn_n = 0;
    sfif_host_model_inst.xfer(tx, nb, rx_bits);
    repeat (10) @(posedge clock);
  endtask

  task automatic finish_test;
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_ops;
    ops = '{8'h06, 8'h50, 8'h04, 8'hb9, 8'hc7};
    foreach (ops[i])
    begin
      frame({56'h0, ops[i]}, 8);
      chk("wr_go", 1, go_n);
      chk("wr_op", ops[i], go_op);
    end
    frame({55'h0, 8'h06, 1'h0}, 9);
    chk("wr_odd_go", 0, go_n);
  endtask

  task automatic t_erase;
    ops = '{8'h20, 8'h52, 8'hd8, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      frame({32'h0, ops[i], 24'h12_3456}, 32);
      chk("er_go", 1, go_n);
      chk("er_addr", 32'h0012_3456, go_addr);
    end
    frame({29'h0, 8'h20, 24'h12_3456, 3'h0}, 35);
    chk("er_odd_go", 0, go_n);
  endtask

  task automatic t_program;
    frame({16'h0, 8'h02, 24'h12_37ff, 16'h5aa5}, 48);
    chk("pg_go", 1, go_n);
    chk("pg_wv", 2, wv_n);
    chk("pg_byte", 8'ha5, wr_last);
    frame({48'h0, 8'h01, 8'h3c}, 16);
    chk("ws_go", 1, go_n);
    chk("ws_byte", 8'h3c, wr_last);
  endtask

  task automatic t_read;
    // Ends five bits into the second byte: reads need no alignment
    frame({19'h0, 8'h03, 24'h00_0100, 13'h0}, 45);
    chk("rd_start", 1, rd_n);
    chk("rd_byte", 8'hb4, rx_bits[12:5]);
    chk("rd_tail", 5'h16, rx_bits[4:0]);
    chk("rd_next", 1, rn_n);
    chk("rd_go", 0, go_n);
    ops = '{8'h05, 8'h35, 8'h9f, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      frame({40'h0, ops[i], 16'h0}, 24);
      chk("rs_byte", 8'hb4, rx_bits[15:8]);
      chk("rs_next", 2, rn_n);
    end
    frame({16'h0, 8'h0b, 24'h00_0200, 16'h0}, 48);
    chk("fr_byte", 8'hb4, rx_bits[7:0]);
    chk("fr_next", 1, rn_n);
  endtask

  task automatic t_busy;
    @(posedge clock);
    busy <= 1'h1;
    frame({56'h0, 8'h06}, 8);
    chk("bz_wr_go", 0, go_n);
    frame({32'h0, 8'h20, 24'h00_1000}, 32);
    chk("bz_er_go", 0, go_n);
    frame({40'h0, 8'h05, 16'h0}, 24);
    chk("bz_rs_byte", 8'hb4, rx_bits[15:8]);
    @(posedge clock);
    busy <= 1'h0;
  endtask

  task automatic t_protect;
    @(posedge clock);
    prot_en <= 1'h1;
    prot_lo <= 24'h12_3800;
    prot_hi <= 24'h12_38ff;
    frame({32'h0, 8'h20, 24'h12_3456}, 32);
    chk("pr_er_go", 0, go_n);
    // Page just below the range must still be accepted
    frame({24'h0, 8'h02, 24'h12_37ff, 8'h11}, 40);
    chk("pr_pg_go", 1, go_n);
    @(posedge clock);
    prot_en <= 1'h0;
  endtask

  task automatic t_unknown;
    frame({24'h0, 8'hff, 8'h06, 24'h0}, 40);
    chk("uk_go", 0, go_n);
    chk("uk_rd", 0, rd_n);
    chk("uk_wv", 0, wv_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    checks = 0;
    go_n = 0;
    rd_n = 0;
    wv_n = 0;
    rn_n = 0;
    arst_n = 1'h1;
    busy = 1'h0;
    prot_en = 1'h0;
    prot_lo = 24'h00_0000;
    prot_hi = 24'h00_0000;
    // Not a bit palindrome, so a reversed bit order cannot pass
    rd_data = 8'hb4;
    // A clean high-to-low step so every asynchronous reset really fires
    #1;
    arst_n = 1'h0;
    @(posedge clock);
    #1;
    chk("rst_oe_n", 1, serial_out_oe_n);
    chk("rst_go", 0, cmd_go);
    chk("rst_op", 0, cmd_op);
    @(posedge clock);
    arst_n <= 1'h1;
    repeat (4) @(posedge clock);
    t_write_ops();
    t_erase();
    t_program();
    t_read();
    t_busy();
    t_protect();
    t_unknown();
    chk("idle_oe_n", 1, serial_out_oe_n);
    finish_test();
  end
endmodule

`default_nettype wire

// *** src/sfif_link.sv ***
`timescale 1ns/10ps
`default_nettype none

module sfif_link (
  input  wire logic spi_clk,
  input  wire logic arst_n,
  input  wire logic cs_n,
  input  wire logic serial_data_line,
  input  wire logic tx_bit,
  input  wire logic tx_oe,
  output logic      bit_tgl,
  output logic      bit_val,
  output logic      serial_out,
  output logic      serial_out_oe_n
);

  // Rising edge: capture one bit and announce it by a toggle
  always_ff @(posedge spi_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_tgl <= 1'b0;
      bit_val <= 1'b0;
    end
    else if (!cs_n)
    begin
      bit_val <= serial_data_line;
      bit_tgl <= ~bit_tgl;
    end
  end

  // Falling edge: launch the bit prepared by the core half a period ago.
  // Deselect releases the pin at once, no clock edge needed.
  always_ff @(negedge spi_clk or negedge arst_n or posedge cs_n)
  begin
    if (!arst_n)
    begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end
    else if (cs_n)
    begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end
    else
    begin
      serial_out      <= tx_bit;
      serial_out_oe_n <= ~tx_oe;
    end
  end

endmodule

`default_nettype wire

// *** src/sfif_pkg.sv ***
package sfif_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OPC   = 3'h1,
    ST_ADDR  = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA  = 3'h6,
    ST_DROP  = 3'h7
  } sfif_state_t;

  typedef struct packed {
    logic        known;
    logic        is_rd;
    logic        is_wr;
    logic        has_addr;
    logic        has_dummy;
    logic        need_data;
    logic [23:0] span;
  } sfif_info_t;

  typedef struct packed {
    logic        cs_prev;
    logic        tgl_prev;
    sfif_state_t state;
    logic [2:0]  bit_cnt;
    logic [1:0]  byte_cnt;
    logic [7:0]  shift;
    sfif_info_t  info;
    logic [7:0]  opc;
    logic        seen_data;
    logic [23:0] addr;
    logic        tx_bit;
    logic        tx_oe;
    logic [6:0]  tx_sh;
    logic [2:0]  tx_cnt;
    logic        load_pend;
    logic        cmd_go;
    logic        rd_start;
    logic        rd_next;
    logic        wr_valid;
    logic [7:0]  wr_byte;
  } sfif_core_t;

endpackage

// *** src/sfif_regs.svh ***
`ifndef SFIF_REGS_SVH
`define SFIF_REGS_SVH

// Opcodes of the fifteen single-lane instructions
`define SFIF_OP_WR_EN       8'h06
`define SFIF_OP_VSR_WR_EN   8'h50
`define SFIF_OP_WR_DIS      8'h04
`define SFIF_OP_RD_STAT1    8'h05
`define SFIF_OP_RD_STAT2    8'h35
`define SFIF_OP_WR_STAT     8'h01
`define SFIF_OP_RD_DATA     8'h03
`define SFIF_OP_RD_FAST     8'h0b
`define SFIF_OP_PROG_PAGE   8'h02
`define SFIF_OP_ERASE_4K    8'h20
`define SFIF_OP_ERASE_32K   8'h52
`define SFIF_OP_ERASE_64K   8'hd8
`define SFIF_OP_ERASE_ALL   8'hc7
`define SFIF_OP_RD_ID       8'h9f
`define SFIF_OP_SLEEP       8'hb9

// Frame layout
`define SFIF_BIT_LAST       3'h7
`define SFIF_ADDR_LAST      2'h2

// Address spans touched by program and erase
`define SFIF_SPAN_NONE      24'h00_0000
`define SFIF_SPAN_PAGE      24'h00_00ff
`define SFIF_SPAN_4K        24'h00_0fff
`define SFIF_SPAN_32K       24'h00_7fff
`define SFIF_SPAN_64K       24'h00_ffff
`define SFIF_SPAN_ALL       24'hff_ffff

// Reset values
`define SFIF_CS_IDLE        1'h1
`define SFIF_TGL_RST        1'h0

`endif

// *** src/sfif_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module sfif_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= RST;
      dout   <= RST;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

// *** src/sfif_top.sv ***
// Notes on behaviour
// - Select falling edge opens a frame and starts opcode decoding.
// - First eight bits after frame start form the opcode, fifteen known.
// - Input bits are taken on rising clock edges, most significant first.
// - Opcode decides whether address, dummy or data bytes follow.
// - Select rising edge completes the current instruction.
// - Read instructions may end after any clocked bit.
// - Write, program, erase act only when ended on a byte boundary.
// - While busy internally, only the status register 1 read (05h) is accepted.
// - Program or erase touching a protected range is discarded.
`include "sfif_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sfif_top (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        spi_clk,
  input  wire logic        cs_n,
  input  wire logic        serial_data_line,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  input  wire logic        busy,
  input  wire logic        prot_en,
  input  wire logic [23:0] prot_lo,
  input  wire logic [23:0] prot_hi,
  input  wire logic [7:0]  rd_data,
  output logic             cmd_go,
  output logic [7:0]       cmd_op,
  output logic [23:0]      cmd_addr,
  output logic             rd_start,
  output logic             rd_next,
  output logic             wr_valid,
  output logic [7:0]       wr_byte
);
  import sfif_pkg::*;

  localparam sfif_core_t CORE_RST = '{
    cs_prev  : `SFIF_CS_IDLE,
    tgl_prev : `SFIF_TGL_RST,
    state    : ST_IDLE,
    default  : '0
  };

  ////////////////////////////////////////////////////////////////////////////

  function automatic sfif_info_t op_info(input logic [7:0] op);
    sfif_info_t i;
    i = '0;
    i.known = 1'b1;
    case (op)
      `SFIF_OP_WR_EN, `SFIF_OP_VSR_WR_EN, `SFIF_OP_WR_DIS, `SFIF_OP_SLEEP:
        i.is_wr = 1'b1;
      `SFIF_OP_WR_STAT:
      begin
        i.is_wr     = 1'b1;
        i.need_data = 1'b1;
      end
      `SFIF_OP_RD_STAT1, `SFIF_OP_RD_STAT2, `SFIF_OP_RD_ID:
        i.is_rd = 1'b1;
      `SFIF_OP_RD_DATA:
      begin
        i.is_rd    = 1'b1;
        i.has_addr = 1'b1;
      end
      `SFIF_OP_RD_FAST:
      begin
        i.is_rd     = 1'b1;
        i.has_addr  = 1'b1;
        i.has_dummy = 1'b1;
      end
      `SFIF_OP_PROG_PAGE:
      begin
        i.is_wr     = 1'b1;
        i.has_addr  = 1'b1;
        i.need_data = 1'b1;
        i.span      = `SFIF_SPAN_PAGE;
      end
      `SFIF_OP_ERASE_4K:
      begin
        i.is_wr    = 1'b1;
        i.has_addr = 1'b1;
        i.span     = `SFIF_SPAN_4K;
      end
      `SFIF_OP_ERASE_32K:
      begin
        i.is_wr    = 1'b1;
        i.has_addr = 1'b1;
        i.span     = `SFIF_SPAN_32K;
      end
      `SFIF_OP_ERASE_64K:
      begin
        i.is_wr    = 1'b1;
        i.has_addr = 1'b1;
        i.span     = `SFIF_SPAN_64K;
      end
      `SFIF_OP_ERASE_ALL:
      begin
        i.is_wr = 1'b1;
        i.span  = `SFIF_SPAN_ALL;
      end
      default:
        i.known = 1'b0;
    endcase
    return i;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link half and crossings

  sfif_core_t  q;
  sfif_core_t  d;
  logic        link_tgl;
  logic        link_bit;
  logic        cs_s;
  logic        tgl_s;
  logic        cs_fall;
  logic        cs_rise;
  logic        bit_evt;
  logic        byte_done;
  logic [7:0]  byte_in;
  sfif_info_t  in_info;
  logic        busy_lock;
  logic [23:0] span_lo;
  logic [23:0] span_hi;
  logic        prot_hit;
  logic        wr_ok;
  logic        rd_msb;

  sfif_link u_link (
    .spi_clk          (spi_clk),
    .arst_n           (arst_n),
    .cs_n             (cs_n),
    .serial_data_line (serial_data_line),
    .tx_bit           (q.tx_bit),
    .tx_oe            (q.tx_oe),
    .bit_tgl          (link_tgl),
    .bit_val          (link_bit),
    .serial_out       (serial_out),
    .serial_out_oe_n  (serial_out_oe_n)
  );

  // Select and bit toggle pass the same depth so their order is kept
  sfif_sync #(.W(2), .RST({`SFIF_CS_IDLE, `SFIF_TGL_RST})) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    ({cs_n, link_tgl}),
    .dout   ({cs_s, tgl_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoding

  assign cs_fall   = q.cs_prev & ~cs_s;
  assign cs_rise   = ~q.cs_prev & cs_s;
  // Captured bit is stable for a whole link period once the toggle shows
  assign bit_evt   = (tgl_s != q.tgl_prev) & ~cs_s;
  assign byte_in   = {q.shift[6:0], link_bit};
  assign byte_done = bit_evt & (q.bit_cnt == `SFIF_BIT_LAST);
  assign in_info   = op_info(byte_in);
  assign busy_lock = busy & (byte_in != `SFIF_OP_RD_STAT1);
  assign span_lo   = q.addr & ~q.info.span;
  assign span_hi   = q.addr | q.info.span;
  assign prot_hit  = prot_en & (q.info.span != `SFIF_SPAN_NONE)
                   & (span_lo <= prot_hi) & (span_hi >= prot_lo);
  assign wr_ok     = q.info.is_wr & (q.state == ST_DATA)
                   & (q.bit_cnt == 3'h0)
                   & (q.seen_data | ~q.info.need_data) & ~prot_hit;
  assign rd_msb    = rd_data[7];

  always_comb
  begin
    d           = q;
    d.cmd_go    = 1'b0;
    d.rd_start  = 1'b0;
    d.rd_next   = 1'b0;
    d.wr_valid  = 1'b0;
    d.load_pend = 1'b0;
    d.cs_prev   = cs_s;
    d.tgl_prev  = tgl_s;
    // Memory answers in the cycle of the request; load before the falling edge
    if (q.load_pend)
    begin
      d.tx_bit = rd_data[7];
      d.tx_sh  = rd_data[6:0];
      d.tx_oe  = 1'b1;
    end
    if (cs_fall)
    begin
      d.state     = ST_OPC;
      d.bit_cnt   = 3'h0;
      d.byte_cnt  = 2'h0;
      d.seen_data = 1'b0;
      d.tx_cnt    = 3'h0;
      d.tx_oe     = 1'b0;
    end
    else if (cs_rise)
    begin
      // Reads need no check and simply stop here
      d.cmd_go = wr_ok;
      d.state  = ST_IDLE;
      d.tx_oe  = 1'b0;
      d.tx_bit = 1'b0;
    end
    else if (bit_evt && (q.state != ST_IDLE))
    begin
      d.shift   = byte_in;
      d.bit_cnt = 3'(q.bit_cnt + 3'h1);
      if ((q.state == ST_DATA) && q.info.is_rd)
      begin
        if (q.tx_cnt == `SFIF_BIT_LAST)
        begin
          d.rd_next   = 1'b1;
          d.load_pend = 1'b1;
          d.tx_cnt    = 3'h0;
        end
        else
        begin
          d.tx_bit = q.tx_sh[6];
          d.tx_sh  = {q.tx_sh[5:0], 1'b0};
          d.tx_cnt = 3'(q.tx_cnt + 3'h1);
        end
      end
      if (byte_done)
      begin
        case (q.state)
          ST_OPC:
          begin
            d.opc  = byte_in;
            d.info = in_info;
            d.addr = 24'h00_0000;
            if (!in_info.known)
              d.state = ST_DROP;
            else if (busy_lock)
              d.state = ST_DROP;
            else if (in_info.has_addr)
              d.state = ST_ADDR;
            else
            begin
              d.state     = ST_DATA;
              d.rd_start  = in_info.is_rd;
              d.load_pend = in_info.is_rd;
            end
          end
          ST_ADDR:
          begin
            d.addr     = {q.addr[15:0], byte_in};
            d.byte_cnt = 2'(q.byte_cnt + 2'h1);
            if (q.byte_cnt == `SFIF_ADDR_LAST)
            begin
              if (q.info.has_dummy)
                d.state = ST_DUMMY;
              else
              begin
                d.state     = ST_DATA;
                d.rd_start  = q.info.is_rd;
                d.load_pend = q.info.is_rd;
              end
            end
          end
          ST_DUMMY:
          begin
            d.state     = ST_DATA;
            d.rd_start  = 1'b1;
            d.load_pend = 1'b1;
          end
          ST_DATA:
          begin
            if (q.info.is_wr)
            begin
              d.wr_valid  = 1'b1;
              d.wr_byte   = byte_in;
              d.seen_data = 1'b1;
            end
          end
          default:
            d.state = q.state;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      q <= CORE_RST;
    else
      q <= d;
  end

  assign cmd_go   = q.cmd_go;
  assign cmd_op   = q.opc;
  assign cmd_addr = q.addr;
  assign rd_start = q.rd_start;
  assign rd_next  = q.rd_next;
  assign wr_valid = q.wr_valid;
  assign wr_byte  = q.wr_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_frame_open: assert property (
    @(posedge clock) disable iff (!arst_n)
    cs_fall |=> (q.state == ST_OPC) && (q.bit_cnt == 3'h0))
    else $error("select fall did not open a frame");

  chk_opcode_take: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_done && !cs_rise && !cs_fall && q.state == ST_OPC)
      |=> (q.opc == $past(byte_in)))
    else $error("opcode byte not captured");

  chk_msb_first: assert property (
    @(posedge clock) disable iff (!arst_n)
    (bit_evt && !cs_fall && !cs_rise && q.state != ST_IDLE)
      |=> (q.shift[0] == $past(link_bit))
          && (q.shift[7:1] == $past(q.shift[6:0])))
    else $error("input bit not shifted in msb first");

  chk_addr_len: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_done && !cs_rise && !cs_fall && q.state == ST_ADDR
      && q.byte_cnt == `SFIF_ADDR_LAST)
      |=> (q.state == ST_DUMMY) || (q.state == ST_DATA))
    else $error("address phase not three bytes");

  chk_frame_close: assert property (
    @(posedge clock) disable iff (!arst_n)
    cs_rise |=> (q.state == ST_IDLE) && !q.tx_oe ##1 !q.cmd_go)
    else $error("frame not closed on select rise");

  chk_read_no_cmd: assert property (
    @(posedge clock) disable iff (!arst_n)
    (cs_rise && q.info.is_rd) |=> !q.cmd_go)
    else $error("read frame issued a command");

  chk_byte_bound: assert property (
    @(posedge clock) disable iff (!arst_n)
    q.cmd_go |-> $past(q.bit_cnt == 3'h0) && $past(cs_rise))
    else $error("command accepted off a byte boundary");

  chk_busy_lock: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_done && !cs_rise && !cs_fall && q.state == ST_OPC && busy_lock)
      |=> (q.state == ST_DROP) [*2])
    else $error("instruction accepted while busy");

  chk_prot_drop: assert property (
    @(posedge clock) disable iff (!arst_n)
    (cs_rise && prot_hit) |=> !q.cmd_go)
    else $error("protected range was touched");

  chk_unknown_op: assert property (
    @(posedge clock) disable iff (!arst_n)
    (byte_done && !cs_rise && !cs_fall && q.state == ST_OPC
      && !in_info.known) |=> (q.state == ST_DROP) && !q.rd_start)
    else $error("unknown opcode not dropped");

  chk_read_load: assert property (
    @(posedge clock) disable iff (!arst_n)
    (q.rd_start && !cs_rise && !cs_fall)
      |=> q.tx_oe && (q.tx_bit == $past(rd_msb)))
    else $error("first read bit not the msb");

endmodule

`default_nettype wire
